// *** led_monitor_pkg.sv ***
// Constants, encodings and register map of the signal-quality indicator.
// Assumes a single system clock domain and a plain strobe register port.
package led_monitor_pkg;

  // Widths of the correction path values, timing inputs and counters.
  localparam int CONV_W = 13;
  localparam int OFFS_W = 13;
  localparam int GAIN_W = 11;
  localparam int IRATE_W = 10;
  localparam int TPP_W = 3;
  localparam int PER_W = 20;
  localparam int HOLD_W = 3;

  // Register port widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Validity limits of the conversion values (signed).
  localparam logic signed [CONV_W-1:0] CONV_LIMIT_POS = 13'sh0FC0;
  localparam logic signed [CONV_W-1:0] CONV_LIMIT_NEG = 13'sh1040;

  // Validity limits of the offset correction values (signed).
  localparam logic signed [OFFS_W-1:0] OFFS_LIMIT_MIN = 13'sh1680;
  localparam logic signed [OFFS_W-1:0] OFFS_LIMIT_MAX = 13'sh097F;

  // Validity limits of the gain correction values (unsigned).
  localparam logic [GAIN_W-1:0] GAIN_LIMIT_MIN = 11'h080;
  localparam logic [GAIN_W-1:0] GAIN_LIMIT_MAX = 11'h77F;

  // Least number of input periods the sensor-check low level stands.
  localparam logic [HOLD_W-1:0] HOLD_PERIODS_DEFAULT = 3'h5;

  // Least period, in system cycles, accepted in counter-only mode.
  localparam logic [PER_W-1:0] COUNTER_MIN_PERIOD = 20'h0005F;

  // Right shift that adds the square-mode margin to the edge budget.
  localparam int SQUARE_MARGIN_SHIFT = 3;

  // Two-bit encoding of the tri-level pad.
  localparam logic [1:0] LEVEL_LOW = 2'h0;
  localparam logic [1:0] LEVEL_MID = 2'h1;
  localparam logic [1:0] LEVEL_HIGH = 2'h2;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] REG_LEVEL = 8'h0C;

  // Control register fields.
  localparam int CTRL_FUNC_BIT = 0;
  localparam int CTRL_SQMON_BIT = 1;
  localparam int CTRL_OVSPD_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

  // Status and mask register fields.
  localparam int STAT_SENSOR_BIT = 0;
  localparam int STAT_SPEED_BIT = 1;
  localparam int STAT_SQUARE_BIT = 2;
  localparam int STAT_W = 3;
  localparam logic [STAT_W-1:0] STAT_RESET = 3'h0;
  localparam logic [STAT_W-1:0] MASK_RESET = 3'h0;

  // Level register fields.
  localparam int LVL_HOLD_BIT = 2;

  typedef enum logic {
    HOLD_IDLE,
    HOLD_ACTIVE
  } holdState_e;

endpackage

// *** led_signal_quality_monitor.sv ***
// Tri-level signal-quality and brightness indicator with speed monitoring.
// Assumes all inputs come from logic on mclk and periodTick pulses once per input period.
//
// Function
// - Indicator takes low, mid or high levels.
// - Check mode: any invalid value drives low.
// - Check-mode low holds at least five periods.
// - Conversion valid within plus/minus 4032.
// - Offset valid from -2432 to +2431.
// - Gain valid from 128 to 1919.
// - Brightness mode: low dark, high bright.
// - Ambiguous fault direction gives mid level.
// - All gains and conversions valid give mid.
// - One gain high, other low gives mid.
// - Gain too large otherwise drives low.
// - Gain too small otherwise drives high.
// - Conversion too large otherwise drives high.
// - Square mode limit: rate and edge interval.
// - Counter-only limit: oscillator clock only.
module led_signal_quality_monitor #(
  parameter logic [led_monitor_pkg::HOLD_W-1:0] HOLD_PERIODS =
    led_monitor_pkg::HOLD_PERIODS_DEFAULT
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Correction path values.
  input wire logic signed [led_monitor_pkg::CONV_W-1:0] sinConv,
  input wire logic signed [led_monitor_pkg::CONV_W-1:0] cosConv,
  input wire logic signed [led_monitor_pkg::OFFS_W-1:0] sineOffsetCorrection,
  input wire logic signed [led_monitor_pkg::OFFS_W-1:0] cosineOffsetCorrection,
  input wire logic [led_monitor_pkg::GAIN_W-1:0] sineGainCorrection,
  input wire logic [led_monitor_pkg::GAIN_W-1:0] cosineGainCorrection,
  // Input period and output timing.
  input wire logic periodTick,
  input wire logic [led_monitor_pkg::IRATE_W-1:0] interpRate,
  input wire logic [led_monitor_pkg::TPP_W-1:0] tppCode,
  // Register port.
  input wire logic [led_monitor_pkg::ADDR_W-1:0] address,
  input wire logic [led_monitor_pkg::DATA_W-1:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [led_monitor_pkg::DATA_W-1:0] readData,
  // Indicator and interrupt.
  output logic [1:0] ledLevel,
  output logic irq
);
  import led_monitor_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [STAT_W-1:0] stat;
    logic [STAT_W-1:0] mask;
    holdState_e holdState;
    logic [HOLD_W-1:0] holdCnt;
    logic [PER_W-1:0] perCnt;
    logic primed;
    logic [1:0] level;
    logic [DATA_W-1:0] rdata;
  } regs_s;

  regs_s r_ff;
  regs_s nxt_r;

  logic sinConvHigh;
  logic cosConvHigh;
  logic convHigh;
  logic offsBad;
  logic sinGainHigh;
  logic cosGainHigh;
  logic sinGainLow;
  logic cosGainLow;
  logic gainHigh;
  logic gainLow;
  logic crossGain;
  logic anyInvalid;
  logic brightMode;
  logic squareMonitor;
  logic overspeedEnable;
  logic [PER_W-1:0] edgeBudget;
  logic [PER_W-1:0] squareMinPeriod;
  logic periodValid;
  logic speedEvent;
  logic squareEvent;
  logic sensorEvent;
  logic [STAT_W-1:0] events;
  logic [STAT_W-1:0] clearBits;
  logic [1:0] brightLevel;

  always_comb begin
    nxt_r = r_ff;
    brightMode = r_ff.ctrl[CTRL_FUNC_BIT];
    squareMonitor = r_ff.ctrl[CTRL_SQMON_BIT];
    overspeedEnable = r_ff.ctrl[CTRL_OVSPD_BIT];

    // Range checks on the correction path.
    sinConvHigh = (sinConv > CONV_LIMIT_POS) || (sinConv < CONV_LIMIT_NEG);
    cosConvHigh = (cosConv > CONV_LIMIT_POS) || (cosConv < CONV_LIMIT_NEG);
    convHigh = sinConvHigh || cosConvHigh;
    offsBad = (sineOffsetCorrection < OFFS_LIMIT_MIN) ||
              (sineOffsetCorrection > OFFS_LIMIT_MAX) ||
              (cosineOffsetCorrection < OFFS_LIMIT_MIN) ||
              (cosineOffsetCorrection > OFFS_LIMIT_MAX);
    sinGainHigh = sineGainCorrection > GAIN_LIMIT_MAX;
    cosGainHigh = cosineGainCorrection > GAIN_LIMIT_MAX;
    sinGainLow = sineGainCorrection < GAIN_LIMIT_MIN;
    cosGainLow = cosineGainCorrection < GAIN_LIMIT_MIN;
    gainHigh = sinGainHigh || cosGainHigh;
    gainLow = sinGainLow || cosGainLow;
    anyInvalid = convHigh || offsBad || gainHigh || gainLow;

    // Brightness decision; offset faults do not point a direction, so they stay mid.
    crossGain = (sinGainHigh && cosGainLow) || (cosGainHigh && sinGainLow);
    if (crossGain) begin
      brightLevel = LEVEL_MID;
    end else if (gainHigh) begin
      brightLevel = LEVEL_LOW;
    end else if (gainLow) begin
      brightLevel = LEVEL_HIGH;
    end else if (convHigh) begin
      brightLevel = LEVEL_HIGH;
    end else begin
      brightLevel = LEVEL_MID;
    end

    // Sensor-check hold; it counts only on periodTick, so a stalled sensor keeps it low.
    sensorEvent = 1'b0;
    if (brightMode) begin
      nxt_r.holdState = HOLD_IDLE;
      nxt_r.holdCnt = '0;
    end else begin
      case (r_ff.holdState)
        HOLD_IDLE: begin
          if (anyInvalid) begin
            nxt_r.holdState = HOLD_ACTIVE;
            nxt_r.holdCnt = HOLD_PERIODS;
            sensorEvent = 1'b1;
          end
        end
        HOLD_ACTIVE: begin
          if (periodTick && (r_ff.holdCnt != '0)) begin
            nxt_r.holdCnt = r_ff.holdCnt - 1'b1;
          end
          if ((r_ff.holdCnt == '0) && !anyInvalid) begin
            nxt_r.holdState = HOLD_IDLE;
          end
        end
        default: begin
          nxt_r.holdState = HOLD_IDLE;
          nxt_r.holdCnt = '0;
        end
      endcase
    end

    // Registered tri-level code.
    if (brightMode) begin
      nxt_r.level = brightLevel;
    end else if (nxt_r.holdState == HOLD_ACTIVE) begin
      nxt_r.level = LEVEL_LOW;
    end else begin
      nxt_r.level = LEVEL_HIGH;
    end

    // Period measurement against the active frequency limit.
    edgeBudget = PER_W'(interpRate) << tppCode;
    squareMinPeriod = edgeBudget + (edgeBudget >> SQUARE_MARGIN_SHIFT);
    periodValid = periodTick && r_ff.primed;
    speedEvent = 1'b0;
    squareEvent = 1'b0;
    if (periodTick) begin
      nxt_r.perCnt = PER_W'(1);
      nxt_r.primed = 1'b1;
    end else if (r_ff.perCnt != '1) begin
      nxt_r.perCnt = r_ff.perCnt + 1'b1;
    end
    if (periodValid && overspeedEnable) begin
      if (squareMonitor) begin
        speedEvent = r_ff.perCnt < squareMinPeriod;
      end else begin
        speedEvent = r_ff.perCnt < COUNTER_MIN_PERIOD;
      end
    end
    if (periodValid && squareMonitor) begin
      squareEvent = r_ff.perCnt < squareMinPeriod;
    end

    // Sticky status: a new event wins over a write-one clear in the same cycle.
    events = '0;
    events[STAT_SENSOR_BIT] = sensorEvent;
    events[STAT_SPEED_BIT] = speedEvent;
    events[STAT_SQUARE_BIT] = squareEvent;
    clearBits = '0;
    if (writeStrobe && (address == REG_STATUS)) begin
      clearBits = writeData[STAT_W-1:0];
    end
    nxt_r.stat = (r_ff.stat & ~clearBits) | events;

    // Register writes.
    if (writeStrobe && (address == REG_CTRL)) begin
      nxt_r.ctrl = writeData[CTRL_W-1:0];
    end
    if (writeStrobe && (address == REG_IRQ_MASK)) begin
      nxt_r.mask = writeData[STAT_W-1:0];
    end

    // Read data stands only in the cycle after the strobe.
    nxt_r.rdata = '0;
    if (readStrobe) begin
      case (address)
        REG_CTRL: nxt_r.rdata = DATA_W'(r_ff.ctrl);
        REG_STATUS: nxt_r.rdata = DATA_W'(r_ff.stat);
        REG_IRQ_MASK: nxt_r.rdata = DATA_W'(r_ff.mask);
        REG_LEVEL: begin
          nxt_r.rdata = DATA_W'(r_ff.level);
          nxt_r.rdata[LVL_HOLD_BIT] = (r_ff.holdState == HOLD_ACTIVE);
        end
        default: nxt_r.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      r_ff.ctrl <= CTRL_RESET;
      r_ff.stat <= STAT_RESET;
      r_ff.mask <= MASK_RESET;
      r_ff.holdState <= HOLD_IDLE;
      r_ff.holdCnt <= '0;
      r_ff.perCnt <= '0;
      r_ff.primed <= 1'b0;
      r_ff.level <= LEVEL_HIGH;
      r_ff.rdata <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign readData = r_ff.rdata;
  assign ledLevel = r_ff.level;
  assign irq = |(r_ff.stat & r_ff.mask);

endmodule

// *** led_pad_model.sv ***
// Tri-level pad driver model standing at the indicator output.
// Assumes ledLevel is the registered two-bit level code of the block.
module led_pad_model (
  // Level code from the block.
  input wire logic [1:0] ledLevel,
  // Pad, released at mid so an outside divider gives half supply.
  output wire logic pad
);
  import led_monitor_pkg::*;
  assign pad = (ledLevel == LEVEL_HIGH) ? 1'b1 : (ledLevel == LEVEL_LOW) ? 1'b0 : 1'bz;
endmodule

// *** led_monitor_assertions.sv ***
// Concurrent checks tying the indicator level to its inputs.
// Assumes it is bound to the top module and sees only its ports.
module led_monitor_assertions (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Watched ports.
  input wire logic signed [led_monitor_pkg::CONV_W-1:0] sinConv,
  input wire logic signed [led_monitor_pkg::CONV_W-1:0] cosConv,
  input wire logic signed [led_monitor_pkg::OFFS_W-1:0] sineOffsetCorrection,
  input wire logic signed [led_monitor_pkg::OFFS_W-1:0] cosineOffsetCorrection,
  input wire logic [led_monitor_pkg::GAIN_W-1:0] sineGainCorrection,
  input wire logic [led_monitor_pkg::GAIN_W-1:0] cosineGainCorrection,
  input wire logic [led_monitor_pkg::ADDR_W-1:0] address,
  input wire logic [led_monitor_pkg::DATA_W-1:0] writeData,
  input wire logic writeStrobe,
  input wire logic [1:0] ledLevel
);
  import led_monitor_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // The mode is mirrored from register writes so no internal probe is needed.
  logic mode_ff;
  always_ff @(posedge mclk) begin
    if (!resetn) mode_ff <= 1'b0;
    else if (writeStrobe && address == REG_CTRL) mode_ff <= writeData[CTRL_FUNC_BIT];
  end
  wire sHi = sineGainCorrection > GAIN_LIMIT_MAX;
  wire cHi = cosineGainCorrection > GAIN_LIMIT_MAX;
  wire sLo = sineGainCorrection < GAIN_LIMIT_MIN;
  wire cLo = cosineGainCorrection < GAIN_LIMIT_MIN;
  wire gHi = sHi || cHi;
  wire gLo = sLo || cLo;
  wire xg = (sHi && cLo) || (sLo && cHi);
  wire cvBad = sinConv > CONV_LIMIT_POS || sinConv < CONV_LIMIT_NEG ||
    cosConv > CONV_LIMIT_POS || cosConv < CONV_LIMIT_NEG;
  wire ofBad = sineOffsetCorrection > OFFS_LIMIT_MAX ||
    sineOffsetCorrection < OFFS_LIMIT_MIN || cosineOffsetCorrection > OFFS_LIMIT_MAX ||
    cosineOffsetCorrection < OFFS_LIMIT_MIN;
  level_code_a: assert property (ledLevel != 2'h3)
    else $error("Level code out of set.");
  conv_range_a: assert property (!mode_ff && cvBad |=> ledLevel == LEVEL_LOW)
    else $error("Bad conversion not low.");
  offs_range_a: assert property (!mode_ff && ofBad |=> ledLevel == LEVEL_LOW)
    else $error("Bad offset not low.");
  gain_range_a: assert property (!mode_ff && (gHi || gLo) |=> ledLevel == LEVEL_LOW)
    else $error("Bad gain not low.");
  bright_ok_a: assert property (mode_ff && !gHi && !gLo && !cvBad |=> ledLevel == LEVEL_MID)
    else $error("Good signals not mid.");
  cross_gain_a: assert property (mode_ff && xg |=> ledLevel == LEVEL_MID)
    else $error("Crossed gains not mid.");
  gain_high_a: assert property (mode_ff && gHi && !xg |=> ledLevel == LEVEL_LOW)
    else $error("Gain high not low.");
  gain_low_a: assert property (mode_ff && gLo && !gHi |=> ledLevel == LEVEL_HIGH)
    else $error("Gain low not high.");
  conv_high_a: assert property (mode_ff && cvBad && !gHi && !gLo |=> ledLevel == LEVEL_HIGH)
    else $error("Conversion high not high.");
  cover property (mode_ff && xg);
  cover property (!mode_ff && gHi);
  cover property (mode_ff && cvBad && gHi);
endmodule
bind led_signal_quality_monitor led_monitor_assertions chk (.mclk, .resetn, .sinConv,
  .cosConv, .sineOffsetCorrection, .cosineOffsetCorrection, .sineGainCorrection,
  .cosineGainCorrection, .address, .writeData, .writeStrobe, .ledLevel);

// *** led_signal_quality_monitor_tb_top.sv ***
// Self-checking bench of the signal-quality indicator.
// Assumes the package, the design, the pad model and the checker compile first.
module led_signal_quality_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import led_monitor_pkg::*;
  localparam logic [GAIN_W-1:0] NG = 11'h3E8;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic signed [CONV_W-1:0] sinConv = '0;
  logic signed [OFFS_W-1:0] sOff = '0;
  logic [GAIN_W-1:0] sGain = NG;
  logic [GAIN_W-1:0] cGain = NG;
  logic periodTick = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic [DATA_W-1:0] writeData = '0;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic [DATA_W-1:0] readData;
  logic [1:0] ledLevel;
  logic irq;
  wire logic pad;
  int miscompares = 0;
  int compares = 0;
  led_signal_quality_monitor #(.HOLD_PERIODS(3'h2)) dut (.mclk(mclk), .resetn(resetn),
    .sinConv(sinConv), .cosConv(13'sh0000), .sineOffsetCorrection(sOff),
    .cosineOffsetCorrection(13'sh0000), .sineGainCorrection(sGain),
    .cosineGainCorrection(cGain), .periodTick(periodTick), .interpRate(10'h010),
    .tppCode(3'h0), .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData), .ledLevel(ledLevel), .irq(irq));
  led_pad_model padModel (.ledLevel(ledLevel), .pad(pad));
  initial forever #5 mclk = ~mclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge mclk);
    writeStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge mclk);
    readStrobe <= 1'b0;
    #1 chk(readData, e);
  endtask
  task automatic tick(input int gap);
    cyc(gap);
    periodTick <= 1'b1;
    @(posedge mclk);
    periodTick <= 1'b0;
  endtask
  // Restoring good values and giving two periods lets any hold run out.
  task automatic probe(input logic signed [12:0] c, input logic signed [12:0] o,
    input logic [10:0] sg, input logic [10:0] cg, input logic [1:0] e);
    @(posedge mclk);
    sinConv <= c;
    sOff <= o;
    sGain <= sg;
    cGain <= cg;
    cyc(2);
    #1 chk(ledLevel, e);
    @(posedge mclk);
    sinConv <= '0;
    sOff <= '0;
    sGain <= NG;
    cGain <= NG;
    tick(1);
    tick(1);
    cyc(2);
  endtask
  task automatic t_reset();
    #1 chk(ledLevel, LEVEL_HIGH);
    chk(irq, 1'b0);
    rd(REG_CTRL, 0);
    rd(REG_STATUS, 0);
    rd(REG_IRQ_MASK, 0);
    rd(8'h10, 0);
    rd(REG_LEVEL, 32'h2);
    @(posedge mclk);
    #1 chk(readData, 0);
    $display("test reset done");
  endtask
  task automatic t_hold();
    wr(REG_IRQ_MASK, 1);
    @(posedge mclk);
    sGain <= 11'h7D0;
    cyc(2);
    #1 chk(ledLevel, LEVEL_LOW);
    chk(irq, 1'b1);
    @(posedge mclk);
    sGain <= NG;
    tick(1);
    cyc(2);
    #1 chk(ledLevel, LEVEL_LOW);
    tick(1);
    cyc(2);
    #1 chk(ledLevel, LEVEL_HIGH);
    wr(REG_STATUS, 1);
    rd(REG_STATUS, 0);
    chk(irq, 1'b0);
    $display("test hold done");
  endtask
  task automatic t_bounds();
    probe(13'sh0FC0, '0, NG, NG, LEVEL_HIGH);
    probe(13'sh0FC1, '0, NG, NG, LEVEL_LOW);
    probe(-13'sh0FC1, '0, NG, NG, LEVEL_LOW);
    probe('0, -13'sh0980, NG, NG, LEVEL_HIGH);
    probe('0, -13'sh0981, NG, NG, LEVEL_LOW);
    probe('0, 13'sh097F, NG, NG, LEVEL_HIGH);
    probe('0, 13'sh0980, NG, NG, LEVEL_LOW);
    probe('0, '0, 11'h080, NG, LEVEL_HIGH);
    probe('0, '0, 11'h07F, NG, LEVEL_LOW);
    probe('0, '0, 11'h77F, NG, LEVEL_HIGH);
    probe('0, '0, 11'h780, NG, LEVEL_LOW);
    $display("test bounds done");
  endtask
  task automatic t_bright();
    wr(REG_CTRL, 1);
    probe('0, 13'sh0980, NG, NG, LEVEL_MID);
    chk(pad, 1'bz);
    probe('0, '0, 11'h7D0, NG, LEVEL_LOW);
    probe('0, '0, 11'h064, NG, LEVEL_HIGH);
    probe('0, '0, 11'h7D0, 11'h064, LEVEL_MID);
    probe(13'sh0FC1, '0, NG, NG, LEVEL_HIGH);
    probe(13'sh0FC1, '0, 11'h7D0, NG, LEVEL_LOW);
    wr(REG_CTRL, 0);
    $display("test brightness done");
  endtask
  task automatic t_speed();
    wr(REG_CTRL, 4);
    tick(120);
    cyc(2);
    wr(REG_STATUS, 7);
    tick(120);
    cyc(2);
    rd(REG_STATUS, 0);
    tick(40);
    cyc(2);
    rd(REG_STATUS, 2);
    wr(REG_CTRL, 6);
    tick(10);
    tick(10);
    rd(REG_STATUS, 6);
    wr(REG_STATUS, 7);
    tick(20);
    cyc(2);
    rd(REG_STATUS, 0);
    wr(REG_CTRL, 0);
    $display("test speed done");
  endtask
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(5);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_hold();
    t_bounds();
    t_bright();
    t_speed();
    end_sim();
  end
  // The tests need under a thousand cycles, so this span of ten thousand only trips on a hang.
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule
